// File: mgfc_pkg.sv
// Constants and types for the mailbox, pin-nine/global pin config and
// pixel clock edge counter register slice.
// Assumes a single core clock; all users refer to names as mgfc_pkg::name.
`default_nettype none

package mgfc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register offsets
    localparam logic [7:0] ADDR_MAILBOX_A  = 8'h18;
    localparam logic [7:0] ADDR_MAILBOX_B  = 8'h19;
    localparam logic [7:0] ADDR_PIN_CFG    = 8'h1A;
    localparam logic [7:0] ADDR_EDGE_COUNT = 8'h1B;

    ////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [7:0] RST_MAILBOX_A  = 8'h00;
    localparam logic [7:0] RST_MAILBOX_B  = 8'h01;
    localparam logic [7:0] RST_PIN_CFG    = 8'h00;
    localparam logic [7:0] RST_EDGE_COUNT = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // Field positions in the pin config register
    localparam int POS_GLOBAL_LEVEL = 7;
    localparam int POS_GLOBAL_DIR   = 5;
    localparam int POS_GLOBAL_EN    = 4;
    localparam int POS_NINE_LEVEL   = 3;
    localparam int POS_NINE_DIR     = 1;
    localparam int POS_NINE_EN      = 0;

    // Writable bits; bits 6 and 2 are reserved
    localparam logic [7:0] PIN_CFG_WMASK = 8'hBB;

    // Counter saturation value
    localparam logic [7:0] EDGE_COUNT_MAX = 8'hFF;

    // Nominal oscillator period; one window unit is one oscillator period
    localparam int OSC_PERIOD_NS = 50;

    ////////////////////////////////////////////////////////////////////////
    // {dir, en} pad configuration pair
    typedef enum logic [1:0] {
        PAD_FUNCTIONAL = 2'b00,
        PAD_GPIO_OUT   = 2'b01,
        PAD_TRISTATE   = 2'b10,
        PAD_GPIO_IN    = 2'b11
    } mgfc_pad_mode_t;

    // Global force settings for every pin whose own pair is functional (00)
    typedef struct packed {
        logic           level;
        mgfc_pad_mode_t mode;
    } mgfc_global_cfg_t;

    // Drive of one pad
    typedef struct packed {
        logic oe;
        logic out;
    } mgfc_pad_drive_t;

endpackage : mgfc_pkg

`default_nettype wire

// File: mgfc_regs.sv
// Register slice: two scratch mailboxes, pin nine plus global pin config,
// and the pixel clock edge counter.
// Assumes the control port, oscillator clock and pixel clock levels are
// all synchronous to i_core_clk; pixel clock must stay at or below half the
// core clock rate to have every edge seen.
`default_nettype none

// Functional notes
// - Two 8-bit mailbox registers read back whatever was last written.
// - After reset, second mailbox reads 0x01 and first mailbox reads zero.
// - Bit 7 level drives pins with own pair 00 when the global pair is 01 (forced out).
// - Global pair: 00 functional, 10 tri-state, 01 forced out, 11 forced in.
// - A pin's own direction and enable settings override the global pair.
// - Global direction at bit 5, global enable at bit 4.
// - Bit 3 level drives pin nine when enabled as output, remote off.
// - Pin nine pair: 00 functional, 10 tri-state, 01 output, 11 input.
// - Pin nine direction at bit 1, enable at bit 0.
// - Any nonzero write to the counter register starts a pixel edge measurement.
// - Window lasts written value times the oscillator period, nominally 50 ns.
// - Counter read returns edges counted in the latest window, not length.
// - Edge count saturates at 0xFF instead of wrapping.
// - Remote control on makes the pin an output driving the remote level.
module mgfc_regs (
    input  wire logic                      i_core_clk,
    input  wire logic                      i_rst,
    input  wire logic                      i_ce,
    input  wire logic [7:0]                i_reg_addr,
    input  wire logic                      i_reg_wr,
    input  wire logic [7:0]                i_reg_wdata,
    input  wire logic                      i_reg_rd,
    output logic      [7:0]                o_reg_rdata,
    output logic                           o_reg_rvalid,
    input  wire logic                      i_osc_clk,
    input  wire logic                      i_pix_clk,
    input  wire logic                      i_pin_nine_func_out,
    input  wire logic                      i_pin_nine_remote_en,
    input  wire logic                      i_pin_nine_remote_level,
    output mgfc_pkg::mgfc_pad_drive_t      o_pin_nine,
    output mgfc_pkg::mgfc_global_cfg_t     o_global_cfg,
    output logic                           o_meas_busy
);

    ////////////////////////////////////////////////////////////////////////
    // State

    logic [7:0] mailbox_a_reg;
    logic [7:0] mailbox_b_reg;
    logic [7:0] pin_cfg_reg;
    logic [7:0] edge_count_reg;
    logic [7:0] edge_count_next;
    logic [7:0] window_left_reg;
    logic       meas_busy_reg;
    logic [7:0] rdata_reg;
    logic       rvalid_reg;

    logic       wr_mailbox_a;
    logic       wr_mailbox_b;
    logic       wr_pin_cfg;
    logic       wr_edge_count;
    logic       osc_rise;
    logic       pix_rise;

    assign wr_mailbox_a  = i_ce && i_reg_wr && (i_reg_addr == mgfc_pkg::ADDR_MAILBOX_A);
    assign wr_mailbox_b  = i_ce && i_reg_wr && (i_reg_addr == mgfc_pkg::ADDR_MAILBOX_B);
    assign wr_pin_cfg    = i_ce && i_reg_wr && (i_reg_addr == mgfc_pkg::ADDR_PIN_CFG);
    assign wr_edge_count = i_ce && i_reg_wr && (i_reg_addr == mgfc_pkg::ADDR_EDGE_COUNT);

    ////////////////////////////////////////////////////////////////////////
    // Mailboxes
    // Plain storage with no side effect, for messages across the link

    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            mailbox_a_reg <= mgfc_pkg::RST_MAILBOX_A;
            mailbox_b_reg <= mgfc_pkg::RST_MAILBOX_B;
        end
        else
        begin
            if (wr_mailbox_a)
            begin
                mailbox_a_reg <= i_reg_wdata;
            end
            if (wr_mailbox_b)
            begin
                mailbox_b_reg <= i_reg_wdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin config register

    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            pin_cfg_reg <= mgfc_pkg::RST_PIN_CFG;
        end
        else if (wr_pin_cfg)
        begin
            pin_cfg_reg <= i_reg_wdata & mgfc_pkg::PIN_CFG_WMASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pad decode

    mgfc_pkg::mgfc_pad_mode_t global_mode;
    mgfc_pkg::mgfc_pad_mode_t nine_mode;
    logic                     global_level;
    logic                     nine_level;

    assign global_mode  = mgfc_pkg::mgfc_pad_mode_t'({pin_cfg_reg[mgfc_pkg::POS_GLOBAL_DIR],
                                                      pin_cfg_reg[mgfc_pkg::POS_GLOBAL_EN]});
    assign nine_mode    = mgfc_pkg::mgfc_pad_mode_t'({pin_cfg_reg[mgfc_pkg::POS_NINE_DIR],
                                                      pin_cfg_reg[mgfc_pkg::POS_NINE_EN]});
    assign global_level = pin_cfg_reg[mgfc_pkg::POS_GLOBAL_LEVEL];
    assign nine_level   = pin_cfg_reg[mgfc_pkg::POS_NINE_LEVEL];

    // Other pins apply the same global decode outside this slice
    assign o_global_cfg.level = global_level;
    assign o_global_cfg.mode  = global_mode;

    // Remote control outranks both the own and the global pair
    always_comb
    begin
        o_pin_nine.oe  = 1'b0;
        o_pin_nine.out = 1'b0;
        if (i_pin_nine_remote_en)
        begin
            o_pin_nine.oe  = 1'b1;
            o_pin_nine.out = i_pin_nine_remote_level;
        end
        else
        begin
            // Own pair wins whenever it is not functional
            case (nine_mode)
                mgfc_pkg::PAD_GPIO_OUT:
                begin
                    o_pin_nine.oe  = 1'b1;
                    o_pin_nine.out = nine_level;
                end
                mgfc_pkg::PAD_TRISTATE,
                mgfc_pkg::PAD_GPIO_IN:
                begin
                    o_pin_nine.oe  = 1'b0;
                end
                mgfc_pkg::PAD_FUNCTIONAL:
                begin
                    case (global_mode)
                        mgfc_pkg::PAD_FUNCTIONAL:
                        begin
                            o_pin_nine.oe  = 1'b1;
                            o_pin_nine.out = i_pin_nine_func_out;
                        end
                        mgfc_pkg::PAD_GPIO_OUT:
                        begin
                            o_pin_nine.oe  = 1'b1;
                            o_pin_nine.out = global_level;
                        end
                        default:
                        begin
                            o_pin_nine.oe  = 1'b0;
                        end
                    endcase
                end
                default:
                begin
                    o_pin_nine.oe  = 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Edge samplers for the two slow clock levels

    // Bit 0 is the oscillator level, bit 1 the pixel clock level
    logic [1:0] slow_level;
    logic [1:0] slow_rise;

    assign slow_level = {i_pix_clk, i_osc_clk};

    generate
        for (genvar g = 0; g < 2; g++)
        begin : g_slow_edge
            logic prev_reg;

            always_ff @(posedge i_core_clk)
            begin
                if (i_rst)
                begin
                    prev_reg <= 1'b0;
                end
                else if (i_ce)
                begin
                    prev_reg <= slow_level[g];
                end
            end

            // A level already high at reset release counts as one rise
            assign slow_rise[g] = slow_level[g] && !prev_reg;
        end
    endgenerate

    assign osc_rise = slow_rise[0];
    assign pix_rise = slow_rise[1];

    ////////////////////////////////////////////////////////////////////////
    // Measurement window, counted in oscillator periods
    // A rewrite restarts the window and wins over its natural end

    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            window_left_reg <= 8'h00;
            meas_busy_reg   <= 1'b0;
        end
        else if (wr_edge_count)
        begin
            window_left_reg <= i_reg_wdata;
            meas_busy_reg   <= (i_reg_wdata != 8'h00);
        end
        else if (i_ce && meas_busy_reg && osc_rise)
        begin
            window_left_reg <= window_left_reg - 8'h01;
            if (window_left_reg == 8'h01)
            begin
                meas_busy_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pixel edge count
    // Holding at the top keeps a long window from reading as a slow clock

    always_comb
    begin
        edge_count_next = edge_count_reg;
        if (pix_rise && (edge_count_reg != mgfc_pkg::EDGE_COUNT_MAX))
        begin
            edge_count_next = edge_count_reg + 8'h01;
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            edge_count_reg <= mgfc_pkg::RST_EDGE_COUNT;
        end
        else if (wr_edge_count)
        begin
            edge_count_reg <= 8'h00;
        end
        else if (i_ce && meas_busy_reg)
        begin
            edge_count_reg <= edge_count_next;
        end
    end

    assign o_meas_busy = meas_busy_reg;

    ////////////////////////////////////////////////////////////////////////
    // Read port; unmapped offsets read zero
    // A counter read during a window sees a partial count

    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            rdata_reg  <= 8'h00;
            rvalid_reg <= 1'b0;
        end
        else if (i_ce)
        begin
            rvalid_reg <= i_reg_rd;
            if (i_reg_rd)
            begin
                case (i_reg_addr)
                    mgfc_pkg::ADDR_MAILBOX_A:   rdata_reg <= mailbox_a_reg;
                    mgfc_pkg::ADDR_MAILBOX_B:   rdata_reg <= mailbox_b_reg;
                    mgfc_pkg::ADDR_PIN_CFG:     rdata_reg <= pin_cfg_reg;
                    mgfc_pkg::ADDR_EDGE_COUNT:  rdata_reg <= edge_count_reg;
                    default:                    rdata_reg <= 8'h00;
                endcase
            end
        end
    end

    assign o_reg_rdata  = rdata_reg;
    assign o_reg_rvalid = rvalid_reg;

endmodule : mgfc_regs

`default_nettype wire

// File: mgfc_regs_bench.sv
// Self-checking bench for mgfc_regs: mailboxes, pin nine drive, edge counter.
// Assumes the package, design and checker are compiled before this file.
`default_nettype none
module mgfc_regs_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic                       clk = 1'b0;
    logic                       rst = 1'b1;
    logic                       ce = 1'b1;
    logic                       wr = 1'b0;
    logic                       rd = 1'b0;
    logic                       osc = 1'b0;
    logic                       pix = 1'b0;
    logic                       rem_en = 1'b0;
    logic                       func = 1'b0;
    logic                       rem_lvl = 1'b0;
    logic [7:0]                 addr = 8'h00;
    logic [7:0]                 wdata = 8'h00;
    logic [7:0]                 rdata;
    logic                       rvalid;
    logic                       busy;
    logic [3:0]                 div = 4'h0;
    int                         err_count = 0;
    int                         num_checks = 0;
    int                         win_len = 0;
    mgfc_pkg::mgfc_pad_drive_t  pin;
    mgfc_pkg::mgfc_global_cfg_t gcfg;
    // Entry: {func out, remote level, remote enable, config byte, expected oe, expected out}
    logic [12:0] tbl [14] = '{13'h1003, 13'h0002, 13'h0006, 13'h0027, 13'h0008, 13'h000C,
                              13'h1042, 13'h0243, 13'h1080, 13'h00C0, 13'h1246, 13'h0118,
                              13'h0C0B, 13'h1426};

    mgfc_regs uut (.i_core_clk(clk), .i_rst(rst), .i_ce(ce), .i_reg_addr(addr),
        .i_reg_wr(wr), .i_reg_wdata(wdata), .i_reg_rd(rd), .o_reg_rdata(rdata),
        .o_reg_rvalid(rvalid), .i_osc_clk(osc), .i_pix_clk(pix), .i_pin_nine_func_out(func),
        .i_pin_nine_remote_en(rem_en), .i_pin_nine_remote_level(rem_lvl), .o_pin_nine(pin),
        .o_global_cfg(gcfg), .o_meas_busy(busy));

    initial
    begin
        forever #2.5 clk = ~clk;
    end

    // Oscillator every 10 cycles, pixel every 4: slow enough to see all edges
    always @(negedge clk)
    begin
        div <= (div == 4'h9) ? 4'h0 : div + 4'h1;
        osc <= (div >= 4'h5);
        if (div[0])
            pix <= ~pix;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
        @(negedge clk);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        check("rvalid", {7'h00, rvalid}, 8'h01);
        v = rdata;
    endtask : rd_reg

    task automatic rd_chk(input string name, input logic [7:0] a, input logic [7:0] e);
        logic [7:0] v;
        rd_reg(a, v);
        check(name, v, e);
    endtask : rd_chk

    // Window start phase against the oscillator is free, so allow one period short
    task automatic measure(input logic [7:0] n, output logic [7:0] v);
        int cyc;
        wr_reg(8'h1B, n);
        check("busy_start", {7'h00, busy}, {7'h00, n != 8'h00});
        cyc = 0;
        while (busy !== 1'b0 && cyc < 3000)
        begin
            @(negedge clk);
            cyc++;
        end
        check("busy_end", {7'h00, busy}, 8'h00);
        win_len = cyc;
        rd_reg(8'h1B, v);
    endtask : measure

    task automatic report_and_stop;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20000) @(posedge clk);
        err_count++;
        report_and_stop();
    end

    initial
    begin
        logic [7:0] v;
        repeat (10) @(negedge clk);
        rst = 1'b0;
        rd_chk("mbox_a", 8'h18, 8'h00);
        rd_chk("mbox_b", 8'h19, 8'h01);
        wr_reg(8'h18, 8'hA5);
        wr_reg(8'h19, 8'h5A);
        rd_chk("mbox_a", 8'h18, 8'hA5);
        rd_chk("mbox_b", 8'h19, 8'h5A);
        wr_reg(8'h20, 8'hFF);
        rd_chk("unmapped", 8'h20, 8'h00);
        ce = 1'b0;
        wr_reg(8'h18, 8'h33);
        ce = 1'b1;
        rd_chk("frozen", 8'h18, 8'hA5);
        foreach (tbl[i])
        begin
            func = tbl[i][12];
            rem_lvl = tbl[i][11];
            rem_en = tbl[i][10];
            wr_reg(8'h1A, tbl[i][9:2]);
            check("pin", {6'h00, pin.oe, pin.oe ? pin.out : 1'b0}, {6'h00, tbl[i][1:0]});
            check("gcfg", {5'h00, gcfg}, {5'h00, tbl[i][9], tbl[i][7:6]});
            rd_chk("pin_cfg", 8'h1A, tbl[i][9:2] & 8'hBB);
        end
        rem_en = 1'b0;
        measure(8'hC8, v);
        check("saturate", v, 8'hFF);
        measure(8'h04, v);
        check("window", {7'h00, v >= 8'h07 && v <= 8'h0A}, 8'h01);
        // Four oscillator periods of 10 cycles, first rise anywhere in the first
        check("window_len", {7'h00, win_len >= 31 && win_len <= 40}, 8'h01);
        measure(8'h00, v);
        check("empty", v, 8'h00);
        // Mid-run reset must bring the written mailboxes back
        rst = 1'b1;
        repeat (3) @(negedge clk);
        rst = 1'b0;
        rd_chk("mbox_a_rst", 8'h18, 8'h00);
        rd_chk("mbox_b_rst", 8'h19, 8'h01);
        report_and_stop();
    end
endmodule : mgfc_regs_bench
`default_nettype wire

// File: mgfc_regs_sva.sv
// Checker for the mgfc_regs register slice, bound onto every instance.
// Assumes one core clock and a synchronous active-high reset.
`default_nettype none
module mgfc_regs_sva (
    input wire logic                       i_core_clk,
    input wire logic                       i_rst,
    input wire logic                       i_ce,
    input wire logic [7:0]                 i_reg_addr,
    input wire logic                       i_reg_wr,
    input wire logic [7:0]                 i_reg_wdata,
    input wire logic                       i_reg_rd,
    input wire logic [7:0]                 o_reg_rdata,
    input wire logic                       o_reg_rvalid,
    input wire logic                       i_osc_clk,
    input wire logic                       i_pin_nine_remote_en,
    input wire logic                       i_pin_nine_remote_level,
    input wire mgfc_pkg::mgfc_pad_drive_t  o_pin_nine,
    input wire mgfc_pkg::mgfc_global_cfg_t o_global_cfg,
    input wire logic                       o_meas_busy
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    logic wr_ok;
    logic rd_ok;
    assign wr_ok = i_ce && i_reg_wr;
    assign rd_ok = i_ce && i_reg_rd;
    sequence cfg_write;
        wr_ok && i_reg_addr == 8'h1A;
    endsequence
    sequence meas_start;
        wr_ok && i_reg_addr == 8'h1B && i_reg_wdata != 8'h00;
    endsequence
    ////////////////////////////////////////////////////////////////////////
    reset_state_a: assert property ($fell(i_rst) |-> o_global_cfg == 3'h0 && !o_meas_busy)
        else $error("state after reset wrong");
    cfg_field_a: assert property (cfg_write |=> o_global_cfg ==
        {$past(i_reg_wdata[7]), $past(i_reg_wdata[5:4])}) else $error("global fields wrong");
    read_pulse_a: assert property (rd_ok ##1 (i_ce && !i_reg_rd) |->
        o_reg_rvalid ##1 !o_reg_rvalid) else $error("read valid not one pulse");
    rdata_hold_a: assert property (!rd_ok |=> $stable(o_reg_rdata))
        else $error("read data changed without read");
    resv_zero_a: assert property (rd_ok && i_reg_addr == 8'h1A |=>
        o_reg_rdata[6] == 1'b0 && o_reg_rdata[2] == 1'b0) else $error("reserved bit set");
    meas_start_a: assert property (meas_start |=> o_meas_busy)
        else $error("window did not start");
    zero_window_a: assert property (wr_ok && i_reg_addr == 8'h1B && i_reg_wdata == 8'h00
        |=> !o_meas_busy) else $error("empty window ran");
    busy_end_a: assert property ($fell(o_meas_busy) && $past(i_ce, 2) &&
        !$past(wr_ok && i_reg_addr == 8'h1B) |-> $past(i_osc_clk) && !$past(i_osc_clk, 2))
        else $error("window ended away from oscillator rise");
    remote_drive_a: assert property (i_pin_nine_remote_en |-> o_pin_nine.oe &&
        o_pin_nine.out == i_pin_nine_remote_level) else $error("remote level not driven");
endmodule : mgfc_regs_sva
bind mgfc_regs mgfc_regs_sva u_sva (.i_core_clk, .i_rst, .i_ce, .i_reg_addr, .i_reg_wr,
    .i_reg_wdata, .i_reg_rd, .o_reg_rdata, .o_reg_rvalid, .i_osc_clk, .i_pin_nine_remote_en,
    .i_pin_nine_remote_level, .o_pin_nine, .o_global_cfg, .o_meas_busy);
`default_nettype wire
